//--- src/smbus_pkg.sv
// shared constants and types of the two-wire bus controller
package smbus_pkg;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL = 10'h0C0;
  localparam logic [9:0] IDX_CFG = 10'h0C1;
  localparam logic [9:0] IDX_DATA = 10'h0C2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ---------------------------------------------------------------
  // bus_control_status bit positions
  // ---------------------------------------------------------------
  localparam int C_MASTER = 7;
  localparam int C_TX = 6;
  localparam int C_STA = 5;
  localparam int C_STO = 4;
  localparam int C_ACK_REQUEST = 3;
  localparam int C_ARB = 2;
  localparam int C_ACK = 1;
  localparam int C_SI = 0;
  // ---------------------------------------------------------------
  // bus_clock_configuration bit positions
  // ---------------------------------------------------------------
  localparam int F_EN = 7;
  localparam int F_INH = 6;
  localparam int F_BUSY = 5;
  localparam int F_EXTH = 4;
  localparam int F_TOE = 3;
  localparam int F_FTE = 2;
  localparam int F_CS = 0;
  // ---------------------------------------------------------------
  // timing: system clocks and source overflow periods
  // ---------------------------------------------------------------
  localparam logic [3:0] HOLD_STD = 4'h3;
  localparam logic [3:0] HOLD_EXT = 4'hC;
  localparam logic [3:0] SETUP_STD = 4'h1;
  localparam logic [3:0] SETUP_EXT = 4'hB;
  localparam logic [3:0] TICK_LOW = 4'h1;
  localparam logic [3:0] TICK_HIGH = 4'h2;
  localparam logic [3:0] TICK_COND = 4'h1;
  localparam logic [3:0] TICK_FREE = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic slave_inhibit;
    logic exth;
    logic toe;
    logic fte;
    logic [1:0] cs;
  } cfg_s;
  typedef struct packed {
    logic scl;
    logic sda;
  } lines_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SWAIT, ST_LOW, ST_HIGH, ST_CLOW, ST_CHIGH
  } st_e;
endpackage

//--- src/smbus_config_control.sv
// two-wire bus controller: configuration, control and bit engine
//
// What this block does
// - master bit is two high, one low periods
// - no scl phase under one source period
// - normal hold 3 clocks, setup 1 clock
// - extended setup 11, hold 12 clocks
// - setup restarts when interrupt flag clears
// - scl high reloads timeout timer, low counts
// - split timer reloads only upper half
// - both lines high over 10 periods frees bus
// - free timeout acts as received stop
// - enable bit gates the whole interface except the start-seen status bit, which a foreign start still sets
// - slave inhibit suppresses slave interrupts except the free bus timeout
// - busy set during transfer, cleared on stop
// - two-bit field selects overflow source
// - start flag starts master, software clears
// - stop flag ends after ack, self clears
// - start with stop gives stop then start
// - received byte requests ack, default nack
// - ack drives sda at once, scl waits
// - nacked address ignores slave until start
// - lost arbitration flagged, cleared with flag
// - interrupt flag stalls scl until cleared
// - inhibit answers nack from next start
`timescale 1ns/1ns
`default_nettype none
module smbus_config_control
  import smbus_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer overflow pulses, index is the source select code
  input wire logic [3:0] ovf_src,
  input wire logic timer_split_mode,
  output logic t2_reload_hi,
  output logic t2_reload_lo,
  // open-drain bus lines
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cfg_s cfg_r;
  st_e st_r, st_nxt;
  lines_s s1_r, s2_r, s3_r;
  logic master_r, tx_r, sta_r, seen_r, sto_r, ack_request_r, arb_r, ack_r;
  logic si_r, busy_r, slave_act_r, data_wr_r, addr_r;
  logic scl_drv_r, sda_drv_r, sda_prev_r;
  logic [7:0] shift_r;
  logic [3:0] bit_r, tick_r, hold_r, setup_r, free_r;
  logic [7:0] ctrl_rd, cfg_rd;
  logic [9:0] idx;
  logic aligned, hit_ctrl, hit_cfg, hit_data, wr_en;
  logic wr_ctrl, wr_cfg, wr_data, si_clr;
  logic scl_hi, scl_rise, scl_fall, start_det, stop_det, tick;
  logic part, tx_eff, want_low, hold_ok, setup_ok, hs_ok;
  logic scl_pull, ev_start, bit_end, ev_stopd, ev_frame, sample;
  logic ev_arb, ev_byte_rx, ev_tx_done, sstop, free_hit, drop;

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    return (v == 4'hF) ? v : v + 4'h1;
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign idx = paddr[11:2];
  assign aligned = paddr[1:0] == 2'b00;
  assign hit_ctrl = aligned & (idx == IDX_CTRL);
  assign hit_cfg = aligned & (idx == IDX_CFG);
  assign hit_data = aligned & (idx == IDX_DATA);
  assign wr_en = psel & penable & pwrite;
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_cfg = wr_en & hit_cfg;
  assign wr_data = wr_en & hit_data;
  assign si_clr = wr_ctrl & ~pwdata[C_SI] & si_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_cfg | hit_data);

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[C_MASTER] = master_r;
    ctrl_rd[C_TX] = tx_r;
    ctrl_rd[C_STA] = seen_r;
    ctrl_rd[C_STO] = sto_r;
    ctrl_rd[C_ACK_REQUEST] = ack_request_r;
    ctrl_rd[C_ARB] = arb_r;
    ctrl_rd[C_ACK] = ack_r;
    ctrl_rd[C_SI] = si_r;
    cfg_rd = 8'h00;
    cfg_rd[F_EN] = cfg_r.en;
    cfg_rd[F_INH] = cfg_r.slave_inhibit;
    cfg_rd[F_BUSY] = busy_r;
    cfg_rd[F_EXTH] = cfg_r.exth;
    cfg_rd[F_TOE] = cfg_r.toe;
    cfg_rd[F_FTE] = cfg_r.fte;
    cfg_rd[F_CS +: 2] = cfg_r.cs;
  end

  // read data is latched in the setup phase, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= 32'h0;
      if (hit_ctrl) prdata[7:0] <= ctrl_rd;
      if (hit_cfg) prdata[7:0] <= cfg_rd;
      if (hit_data) prdata[7:0] <= shift_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= cfg_s'(7'h00);
    end else if (wr_cfg) begin
      cfg_r.en <= pwdata[F_EN];
      cfg_r.slave_inhibit <= pwdata[F_INH];
      cfg_r.exth <= pwdata[F_EXTH];
      cfg_r.toe <= pwdata[F_TOE];
      cfg_r.fte <= pwdata[F_FTE];
      cfg_r.cs <= pwdata[F_CS +: 2];
    end
  end

  // ---------------------------------------------------------------
  // line sampling, conditions and timing
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 2'b11;
      s2_r <= 2'b11;
      s3_r <= 2'b11;
    end else begin
      s1_r <= {scl_i, sda_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign scl_hi = s2_r.scl;
  assign scl_rise = s2_r.scl & ~s3_r.scl;
  assign scl_fall = ~s2_r.scl & s3_r.scl;
  assign start_det = s2_r.scl & s3_r.scl & s3_r.sda & ~s2_r.sda;
  assign stop_det = s2_r.scl & s3_r.scl & ~s3_r.sda & s2_r.sda;
  // source ignored unless master, starting or watching for free bus
  assign tick = ovf_src[cfg_r.cs] & cfg_r.en &
                (master_r | sta_r | cfg_r.fte);

  assign hold_ok = hold_r >= (cfg_r.exth ? HOLD_EXT : HOLD_STD);
  assign setup_ok = setup_r >= (cfg_r.exth ? SETUP_EXT : SETUP_STD);
  assign hs_ok = hold_ok & setup_ok & (sda_drv_r == want_low);

  // hold counts from our own pull as well, since the sampled fall lags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 4'h0;
      setup_r <= 4'h0;
      sda_prev_r <= 1'b0;
    end else begin
      sda_prev_r <= sda_drv_r;
      if (scl_fall | (scl_pull & ~scl_drv_r)) hold_r <= 4'h0;
      else hold_r <= sat_inc(hold_r);
      if ((sda_drv_r != sda_prev_r) | si_clr) setup_r <= 4'h0;
      else setup_r <= sat_inc(setup_r);
    end
  end

  // high phases count only while scl is really seen high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 4'h0;
    end else if (st_nxt != st_r) begin
      tick_r <= 4'h0;
    end else if (tick & (scl_hi | (st_r != ST_HIGH & st_r != ST_CHIGH))) begin
      tick_r <= sat_inc(tick_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_r <= 4'h0;
    end else if (~(s2_r.scl & s2_r.sda) | ~cfg_r.fte) begin
      free_r <= 4'h0;
    end else if (tick & free_r <= TICK_FREE) begin
      free_r <= free_r + 4'h1;
    end
  end
  assign free_hit = cfg_r.fte & tick & (free_r == TICK_FREE) & busy_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_reload_hi <= 1'b0;
      t2_reload_lo <= 1'b0;
    end else begin
      t2_reload_hi <= cfg_r.en & cfg_r.toe & scl_hi;
      t2_reload_lo <= cfg_r.en & cfg_r.toe & scl_hi &
                      ~timer_split_mode;
    end
  end

  // ---------------------------------------------------------------
  // bit engine
  // ---------------------------------------------------------------
  assign part = master_r | slave_act_r;
  assign tx_eff = (bit_r == 4'h0) ? data_wr_r : tx_r;
  assign sample = scl_rise & (st_r == ST_LOW | st_r == ST_HIGH);
  assign ev_arb = sample & (bit_r < BIT_ACK) & part & tx_eff &
                  ~sda_drv_r & ~s2_r.sda;
  assign ev_byte_rx = bit_end & (bit_r == BIT_LAST) & ~tx_r & part;
  assign ev_tx_done = bit_end & (bit_r == BIT_ACK) & tx_r & part;
  assign sstop = stop_det & slave_act_r & ~master_r;
  assign drop = bit_end & (bit_r == BIT_ACK) & addr_r & ~master_r &
                (~ack_r | ~slave_act_r);

  always_comb begin
    want_low = 1'b0;
    if (st_r == ST_CLOW) want_low = sto_r;
    else if (~part) want_low = 1'b0;
    else if (bit_r == BIT_ACK) want_low = ~tx_r & ack_r;
    else want_low = tx_eff & ~shift_r[7];
  end

  always_comb begin
    st_nxt = st_r;
    scl_pull = 1'b0;
    ev_start = 1'b0;
    bit_end = 1'b0;
    ev_stopd = 1'b0;
    ev_frame = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (sta_r & ~busy_r & scl_hi & s2_r.sda) st_nxt = ST_START;
      end
      ST_START: begin
        if (tick_r >= TICK_COND) begin
          scl_pull = 1'b1;
          st_nxt = ST_LOW;
          ev_start = 1'b1;
        end
      end
      ST_SWAIT: begin
        if (scl_fall) st_nxt = ST_LOW;
      end
      ST_LOW: begin
        if (master_r) begin
          scl_pull = 1'b1;
          if (~si_r & (bit_r == 4'h0) & (sto_r | sta_r)) begin
            st_nxt = ST_CLOW;
          end else if (~si_r & hs_ok & tick_r >= TICK_LOW) begin
            scl_pull = 1'b0;
            st_nxt = ST_HIGH;
            ev_frame = bit_r == 4'h0;
          end
        end else begin
          scl_pull = si_r | ~hs_ok;
          if (scl_rise) begin
            st_nxt = ST_HIGH;
            ev_frame = bit_r == 4'h0;
          end
        end
      end
      ST_HIGH: begin
        if (master_r ? (tick_r >= TICK_HIGH | scl_fall) : scl_fall) begin
          scl_pull = master_r;
          st_nxt = ST_LOW;
          bit_end = 1'b1;
        end
      end
      ST_CLOW: begin
        scl_pull = 1'b1;
        if (hs_ok & tick_r >= TICK_LOW) begin
          scl_pull = 1'b0;
          st_nxt = ST_CHIGH;
        end
      end
      ST_CHIGH: begin
        if (tick_r >= TICK_COND) begin
          // stop first; a pending start then waits for the free bus
          st_nxt = sto_r ? ST_IDLE : ST_START;
          ev_stopd = sto_r;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      slave_act_r <= 1'b0;
      addr_r <= 1'b0;
    end else if (~cfg_r.en) begin
      st_r <= ST_IDLE;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      slave_act_r <= 1'b0;
      addr_r <= 1'b0;
    end else if (ev_arb | drop) begin
      st_r <= ST_IDLE;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      slave_act_r <= 1'b0;
      addr_r <= 1'b0;
    end else if (start_det & ~master_r & st_r != ST_START) begin
      st_r <= ST_SWAIT;
      bit_r <= 4'h0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      slave_act_r <= ~cfg_r.slave_inhibit;
      addr_r <= 1'b1;
    end else if ((stop_det | free_hit) & ~master_r) begin
      st_r <= ST_IDLE;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      slave_act_r <= 1'b0;
      addr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      scl_drv_r <= scl_pull;
      if (ev_start) bit_r <= 4'h0;
      else if (bit_end) bit_r <= (bit_r == BIT_ACK) ? 4'h0 : bit_r + 4'h1;
      if (bit_end & bit_r == BIT_ACK) addr_r <= 1'b0;
      if (st_r == ST_IDLE) sda_drv_r <= st_nxt == ST_START;
      else if (st_r == ST_CHIGH & st_nxt != ST_CHIGH) sda_drv_r <= ~sto_r;
      else if ((st_r == ST_LOW | st_r == ST_CLOW) & hold_ok) begin
        sda_drv_r <= want_low;
      end
    end
  end

  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 8'h00;
      data_wr_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      if (sample & bit_r < BIT_ACK) shift_r <= {shift_r[6:0], s2_r.sda};
      else if (wr_data) shift_r <= pwdata[7:0];
      if (start_det & ~master_r) data_wr_r <= 1'b0;
      else if (wr_data) data_wr_r <= 1'b1;
      else if (ev_frame) data_wr_r <= 1'b0;
      if ((start_det & ~master_r) | ev_arb) tx_r <= 1'b0;
      else if (ev_start) tx_r <= 1'b1; // master sends the address first
      else if (ev_frame) tx_r <= data_wr_r;
    end
  end

  // ---------------------------------------------------------------
  // control and status flags, hardware set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      si_r <= CTRL_RESET[C_SI];
      arb_r <= CTRL_RESET[C_ARB];
      seen_r <= CTRL_RESET[C_STA];
      sta_r <= CTRL_RESET[C_STA];
    end else begin
      si_r <= ev_start | ev_byte_rx | ev_tx_done | ev_arb | sstop |
              free_hit | (si_r & ~si_clr);
      arb_r <= ev_arb | (arb_r & ~si_clr);
      seen_r <= ev_start | (start_det & ~master_r & ~cfg_r.slave_inhibit) |
                (seen_r & ~si_clr);
      if (wr_ctrl) sta_r <= pwdata[C_STA];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sto_r <= CTRL_RESET[C_STO];
      ack_request_r <= CTRL_RESET[C_ACK_REQUEST];
      ack_r <= CTRL_RESET[C_ACK];
    end else begin
      if (sstop | free_hit) sto_r <= 1'b1;
      else if (ev_stopd) sto_r <= 1'b0;
      else if (wr_ctrl) sto_r <= pwdata[C_STO];
      if (ev_byte_rx) ack_request_r <= 1'b1;
      else if (bit_end & bit_r == BIT_ACK) ack_request_r <= 1'b0;
      if (ev_byte_rx) ack_r <= 1'b0;
      else if (sample & bit_r == BIT_ACK & tx_r & part) begin
        ack_r <= ~s2_r.sda;
      end else if (wr_ctrl) ack_r <= pwdata[C_ACK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_r <= CTRL_RESET[C_MASTER];
      busy_r <= 1'b0;
    end else if (~cfg_r.en) begin
      master_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      if (ev_start) master_r <= 1'b1;
      else if (ev_stopd | ev_arb) master_r <= 1'b0;
      busy_r <= ev_start | (start_det & ~master_r) |
                (busy_r & ~stop_det & ~free_hit);
    end
  end

  // open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_drv_r;
  assign sda_oe = sda_drv_r;
endmodule
`default_nettype wire

//--- testbench/smbus_config_control_props.sv
// port-level assertions for the two-wire bus controller
`timescale 1ns/1ns
`default_nettype none
module smbus_config_control_props
  import smbus_pkg::*;
(
  // clock, reset and register bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // timers and bus lines
  input wire logic [3:0] ovf_src,
  input wire logic timer_split_mode,
  input wire logic t2_reload_hi,
  input wire logic t2_reload_lo,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cfg_r;
  logic [1:0] ticks_r;
  logic mapped, tick, rl_on, own_r;
  assign mapped = paddr[1:0] == 2'h0 && (paddr[11:2] == IDX_CTRL ||
    paddr[11:2] == IDX_CFG || paddr[11:2] == IDX_DATA);
  assign tick = ovf_src[cfg_r[1:0]];
  assign rl_on = cfg_r[F_EN] && cfg_r[F_TOE] && scl_i;
  // shadow copy, the configuration byte is not visible at the ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 8'h00;
    end else if (psel && penable && pwrite && mapped &&
                 paddr[11:2] == IDX_CFG) begin
      cfg_r <= pwdata[7:0];
    end
  end
  // saturating count of source ticks while scl is pulled low; own_r
  // marks a pull that took scl from high, i.e. a master clock phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks_r <= 2'h0;
      own_r <= 1'b0;
    end else if ($rose(scl_oe)) begin
      ticks_r <= {1'b0, tick};
      own_r <= $past(scl_i);
    end else if (scl_oe && tick && ticks_r != 2'h3) begin
      ticks_r <= ticks_r + 2'h1;
    end
  end
  sequence s_hold_std;
    $stable(sda_oe)[*3];
  endsequence
  sequence s_hold_ext;
    $stable(sda_oe)[*8] ##1 $stable(sda_oe)[*4];
  endsequence
  property p_slverr;
    psel && penable |-> pslverr == !mapped;
  endproperty
  property p_hold_std;
    $rose(scl_oe) && !cfg_r[F_EXTH] |-> s_hold_std;
  endproperty
  property p_hold_ext;
    $rose(scl_oe) && cfg_r[F_EXTH] |-> s_hold_ext;
  endproperty
  property p_low_min;
    $fell(scl_oe) && own_r |-> ticks_r != 2'h0;
  endproperty
  property p_reload_on;
    rl_on [*6] |-> t2_reload_hi;
  endproperty
  property p_reload_split;
    (rl_on && $stable(timer_split_mode)) [*6] |->
      t2_reload_lo == !timer_split_mode;
  endproperty
  property p_reload_off;
    (!rl_on) [*6] |-> !t2_reload_hi && !t2_reload_lo;
  endproperty
  property p_disabled;
    (!cfg_r[F_EN]) [*3] |-> !scl_oe && !sda_oe;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error response does not match address");
  a_hold_std: assert property (p_hold_std)
    else $error("sda changed within normal hold");
  a_hold_ext: assert property (p_hold_ext)
    else $error("sda changed within extended hold");
  a_low_min: assert property (p_low_min)
    else $error("scl low shorter than one source period");
  a_reload_on: assert property (p_reload_on)
    else $error("timer not reloaded while scl high");
  a_reload_split: assert property (p_reload_split)
    else $error("lower timer half reload wrong for split mode");
  a_reload_off: assert property (p_reload_off)
    else $error("timer reload held while scl low or disabled");
  a_disabled: assert property (p_disabled)
    else $error("lines driven while interface disabled");
endmodule
bind smbus_config_control smbus_config_control_props
  smbus_config_control_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .ovf_src(ovf_src), .timer_split_mode(timer_split_mode),
  .t2_reload_hi(t2_reload_hi), .t2_reload_lo(t2_reload_lo),
  .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire

//--- testbench/smbus_slave_model.sv
// behavioural slave on the far side of the bus: acks every byte
`timescale 1ns/1ns
`default_nettype none
module smbus_slave_model (
  // clock and resolved bus lines
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  // behaviour control and last byte taken
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  int bits = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
  end
  // start seen: the following scl fall opens bit 0
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bits = -1;
    end
  end
  always @(posedge scl) begin
    if (bits >= 0 && bits < 8) begin
      sh = {sh[6:0], sda};
    end
  end
  always @(negedge scl) begin
    bits = bits + 1;
    if (bits == 8) begin
      rx_byte = sh;
      sda_oe = 1'b1;
    end else if (bits == 9) begin
      sda_oe = 1'b0;
      bits = 0;
    end
    // low extension: the master must wait, so the rate only drops
    if (stretch) begin
      scl_oe = 1'b1;
      repeat (20) @(posedge pclk);
      scl_oe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/smbus_config_control_test.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ns
`default_nettype none
module smbus_config_control_test
  import smbus_pkg::*;
;
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CFG = {IDX_CFG, 2'b00};
  localparam logic [11:0] A_DATA = {IDX_DATA, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic split = 1'b0;
  logic stretch = 1'b0;
  logic tb_scl_oe = 1'b0;
  logic tb_sda_oe = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ovf_src = 4'h0;
  logic [2:0] div_r = 3'h0;
  logic [1:0] cs = 2'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, scl_oe, sda_oe, m_scl_oe, m_sda_oe, rl_hi, rl_lo;
  logic [7:0] rx_byte, d, cfg;
  logic [16:0] nv;
  logic [16:0] q[$];
  int num_errors = 0;
  int n_tests = 0;
  integer seed = 89809;
  wire scl_w = !(scl_oe || m_scl_oe || tb_scl_oe);
  wire sda_w = !(sda_oe || m_sda_oe || tb_sda_oe);
  smbus_config_control smbus_config_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ovf_src(ovf_src),
    .timer_split_mode(split), .t2_reload_hi(rl_hi), .t2_reload_lo(rl_lo),
    .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
  smbus_slave_model smbus_slave_model_inst (
    .pclk(pclk), .scl(scl_w), .sda(sda_w), .stretch(stretch),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte(rx_byte));
  always #10 pclk = ~pclk;
  // selected source ticks every 160 ns; others toggle at random so a
  // wrong source choice makes scl phases visibly short
  always @(posedge pclk) begin
    div_r <= div_r + 3'h1;
    ovf_src <= (4'($random(seed)) & ~(4'h1 << cs)) |
      (4'(div_r == 3'h7) << cs);
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] v,
            input logic keep, input logic [7:0] e, input logic [7:0] m);
    @(posedge pclk);
    if (keep) q.push_back({!(a == A_CTRL || a == A_CFG || a == A_DATA),
      m, e & m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    xfer(1'b1, a, v, 1'b0, 8'h00, 8'h00);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    xfer(1'b0, a, 8'h00, 1'b1, e, m);
  endtask
  task wait_bit(input logic [11:0] a, input int b, input logic v);
    for (int i = 0; i < 4000; i++) begin
      xfer(1'b0, a, 8'h00, 1'b0, 8'h00, 8'h00);
      if (rdata[b] === v) break;
    end
  endtask
  task complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // read results are compared in order as they appear on the bus
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() != 0) begin
      nv = q.pop_front();
      check({31'h0, pslverr}, {31'h0, nv[16]});
      check(prdata & {24'hFFFFFF, nv[15:8]}, {24'h0, nv[7:0]});
    end
  end
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, CTRL_RESET, 8'hFF);
    rd(A_CFG, CFG_RESET, 8'hFF);
    rd(A_DATA + 12'h4, 8'h00, 8'hFF);
    wr(A_CTRL, 8'hCC);
    rd(A_CTRL, 8'h00, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      cs <= k[1:0];
      split <= 1'($random(seed));
      stretch <= (k == 2);
      cfg = {1'b1, 2'b00, k[0], 2'b10, k[1:0]};
      wr(A_CFG, cfg | 8'h20);
      rd(A_CFG, cfg, 8'hFF);
      wr(A_CTRL, 8'h20);
      wait_bit(A_CTRL, C_SI, 1'b1);
      rd(A_CTRL, 8'hE1, 8'hFD);
      rd(A_CFG, cfg | 8'h20, 8'hFF);
      d = 8'($random(seed));
      wr(A_DATA, d);
      wr(A_CTRL, 8'h00);
      wait_bit(A_CTRL, C_SI, 1'b1);
      rd(A_CTRL, 8'hC3, 8'hFF);
      check({24'h0, rx_byte}, {24'h0, d});
      if (k == 3) begin
        wr(A_CTRL, 8'h30);
        wait_bit(A_CTRL, C_SI, 1'b1);
        rd(A_CTRL, 8'hE1, 8'hFD);
      end
      wr(A_CTRL, 8'h10);
      wait_bit(A_CFG, F_BUSY, 1'b0);
      rd(A_CTRL, 8'h00, 8'hB1);
    end
    // start from another party, then both lines idle high; the second
    // pass has slave events inhibited, so no start is reported
    cs <= 2'h0;
    for (int j = 0; j < 2; j++) begin
      cfg = 8'h84 | {1'b0, j[0], 6'h00};
      wr(A_CFG, cfg);
      tb_sda_oe <= 1'b1;
      repeat (8) @(posedge pclk);
      tb_scl_oe <= 1'b1;
      repeat (8) @(posedge pclk);
      tb_sda_oe <= 1'b0;
      repeat (8) @(posedge pclk);
      tb_scl_oe <= 1'b0;
      repeat (40) @(posedge pclk);
      rd(A_CFG, cfg | 8'h20, 8'hFF);
      rd(A_CTRL, {2'b00, !j[0], 5'h00}, 8'h31);
      repeat (80) @(posedge pclk);
      rd(A_CTRL, {2'b00, !j[0], 5'h11}, 8'h31);
      rd(A_CFG, cfg, 8'hFF);
      wr(A_CTRL, 8'h00);
    end
    wr(A_CFG, 8'h00);
    repeat (10) @(posedge pclk);
    complete_run();
  end
endmodule
`default_nettype wire
